/* File: core/xo_margin_pll_cfg_regs.sv */
// margining offset and synthesizer-one configuration bank on axi4-lite
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module xo_margin_pll_cfg_regs
  import margin_cfg_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [margin_cfg_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [margin_cfg_pkg::DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [margin_cfg_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [margin_cfg_pkg::DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [2:0] step_select_pin_in,
  input wire logic margin_gate_pin_in,
  output logic [margin_cfg_pkg::OFS_W-1:0] active_offset_out,
  output logic synth_one_pulse_stretch_out,
  output logic [margin_cfg_pkg::FILT_W-1:0] synth_one_filter_order_out,
  output logic synth_one_third_order_out,
  output logic [9:0] synth_one_min_pulse_ps_out
);
  import margin_cfg_pkg::*;

  // the split offset word only works when the two stored fields fill it exactly
  if (OFS_W != HIGH_W + BYTE_W)
  begin : g_width_check
    $error("offset width must equal high field plus low byte");
  end

  // write channel holding registers: address and data may arrive apart
  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [DATA_W-1:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic stretch_ff;
  logic [FILT_W-1:0] filter_ff;
  logic [1:0] option_ff;
  logic [OFS_W-1:0] active_ff;
  logic [HIGH_W-1:0] step5_high_q;

  // accept each write channel while no response is pending
  assign s_axi_awready_out = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready_out = !w_held_ff && !bvalid_ff;
  assign s_axi_arready_out = !rvalid_ff;
  wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
  wire w_take = s_axi_wvalid_in && s_axi_wready_out;
  wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
  wire [ADDR_W-1:0] wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr_in;
  wire [DATA_W-1:0] wr_data = w_held_ff ? w_data_ff : s_axi_wdata_in;
  wire [3:0] wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb_in;
  wire wr_fire = (aw_held_ff || aw_take) && (w_held_ff || w_take);

  // word decode; low address bits ignored, only byte lane 0 carries data
  wire [7:0] wr_idx = wr_addr[9:2];
  wire wr_lane0 = wr_fire && wr_strb[0];
  wire wr_aligned = (wr_addr[11:10] == 2'h0);
  wire we_s5l = wr_lane0 && wr_aligned && (wr_idx == IDX_STEP5_LOW);
  wire we_s6h = wr_lane0 && wr_aligned && (wr_idx == IDX_STEP6_HIGH);
  wire we_s6l = wr_lane0 && wr_aligned && (wr_idx == IDX_STEP6_LOW);
  wire we_s7h = wr_lane0 && wr_aligned && (wr_idx == IDX_STEP7_HIGH);
  wire we_s7l = wr_lane0 && wr_aligned && (wr_idx == IDX_STEP7_LOW);
  wire we_s8h = wr_lane0 && wr_aligned && (wr_idx == IDX_STEP8_HIGH);
  wire we_s8l = wr_lane0 && wr_aligned && (wr_idx == IDX_STEP8_LOW);
  wire we_swh = wr_lane0 && wr_aligned && (wr_idx == IDX_SOFT_HIGH);
  wire we_swl = wr_lane0 && wr_aligned && (wr_idx == IDX_SOFT_LOW);
  wire we_pls = wr_lane0 && wr_aligned && (wr_idx == IDX_PULSE_CTRL);
  wire we_flt = wr_lane0 && wr_aligned && (wr_idx == IDX_FILTER_CTRL);
  wire we_opt = wr_lane0 && wr_aligned && (wr_idx == IDX_MARGIN_CTRL);
  wire wr_mapped = wr_aligned && (wr_idx == IDX_STEP5_LOW || wr_idx == IDX_STEP6_HIGH
    || wr_idx == IDX_STEP6_LOW || wr_idx == IDX_STEP7_HIGH || wr_idx == IDX_STEP7_LOW
    || wr_idx == IDX_STEP8_HIGH || wr_idx == IDX_STEP8_LOW || wr_idx == IDX_SOFT_HIGH
    || wr_idx == IDX_SOFT_LOW || wr_idx == IDX_PULSE_CTRL || wr_idx == IDX_FILTER_CTRL
    || wr_idx == IDX_MARGIN_CTRL || wr_idx == IDX_ACTIVE_OFS);

  // step-five high bits live outside this bank; held at zero here
  assign step5_high_q = '0;
  logic [7:0] step5_low_ff;
  logic [OFS_W-1:0] step6_w;
  logic [OFS_W-1:0] step7_w;
  logic [OFS_W-1:0] step8_w;
  logic [OFS_W-1:0] soft_w;

  offset_word_reg #(.HIGH_RST(RST_STEP6_HIGH), .LOW_RST(RST_STEP6_LOW)) u_step6 (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .high_we_in(we_s6h), .low_we_in(we_s6l),
    .wdata_in(wr_data[7:0]), .word_out(step6_w));
  offset_word_reg #(.HIGH_RST(RST_STEP7_HIGH), .LOW_RST(RST_STEP7_LOW)) u_step7 (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .high_we_in(we_s7h), .low_we_in(we_s7l),
    .wdata_in(wr_data[7:0]), .word_out(step7_w));
  offset_word_reg #(.HIGH_RST(RST_STEP8_HIGH), .LOW_RST(RST_STEP8_LOW)) u_step8 (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .high_we_in(we_s8h), .low_we_in(we_s8l),
    .wdata_in(wr_data[7:0]), .word_out(step8_w));
  offset_word_reg #(.HIGH_RST(RST_SOFT_HIGH), .LOW_RST(RST_SOFT_LOW)) u_soft (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .high_we_in(we_swh), .low_we_in(we_swl),
    .wdata_in(wr_data[7:0]), .word_out(soft_w));

  // pins are asynchronous: resynchronise before the selector reads them
  logic [3:0] pins_sync;
  sync_two_ff #(.WIDTH(4)) u_pin_sync (
    .clock_in(clock_in), .rst_b_in(rst_b_in),
    .async_in({margin_gate_pin_in, step_select_pin_in}), .sync_out(pins_sync));
  wire [2:0] step_sel = pins_sync[2:0];
  wire gate_high = pins_sync[3];

  // plain control fields
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      step5_low_ff <= RST_STEP5_LOW;
      stretch_ff <= RST_STRETCH;
      filter_ff <= RST_FILTER;
      option_ff <= RST_OPTION;
    end
    else
    begin
      if (we_s5l)
        step5_low_ff <= wr_data[7:0];
      if (we_pls)
        stretch_ff <= wr_data[STRETCH_BIT];
      if (we_flt)
        filter_ff <= wr_data[FILT_W-1:0];
      if (we_opt)
        option_ff <= wr_data[1:0];
    end
  end

  // step offsets below five come from the preceding bank; unused here
  wire [2:0] eff_step = (option_ff == OPT_PIN_GATED && gate_high) ? NOMINAL_STEP : step_sel;
  wire [OFS_W-1:0] step5_w = {step5_high_q, step5_low_ff};
  wire [OFS_W-1:0] pin_ofs = (eff_step == 3'h4) ? step5_w :
                             (eff_step == 3'h5) ? step6_w :
                             (eff_step == 3'h6) ? step7_w :
                             (eff_step == 3'h7) ? step8_w : {OFS_W{1'b0}};
  wire [OFS_W-1:0] nxt_active = (option_ff == OPT_SOFT) ? soft_w : pin_ofs;

  // registered so the offset output never glitches on a pin edge
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      active_ff <= {OFS_W{1'b0}};
    else
      active_ff <= nxt_active;
  end

  // read decode
  wire [7:0] rd_idx = s_axi_araddr_in[9:2];
  wire rd_aligned = (s_axi_araddr_in[11:10] == 2'h0);
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb
  begin
    rd_byte = 8'h00;
    rd_hit = rd_aligned;
    case (rd_idx)
      IDX_STEP5_LOW: rd_byte = step5_low_ff;
      IDX_STEP6_HIGH: rd_byte = {6'h00, step6_w[9:8]};
      IDX_STEP6_LOW: rd_byte = step6_w[7:0];
      IDX_STEP7_HIGH: rd_byte = {6'h00, step7_w[9:8]};
      IDX_STEP7_LOW: rd_byte = step7_w[7:0];
      IDX_STEP8_HIGH: rd_byte = {6'h00, step8_w[9:8]};
      IDX_STEP8_LOW: rd_byte = step8_w[7:0];
      IDX_SOFT_HIGH: rd_byte = {6'h00, soft_w[9:8]};
      IDX_SOFT_LOW: rd_byte = soft_w[7:0];
      IDX_PULSE_CTRL: rd_byte = {stretch_ff, 7'h00};
      IDX_FILTER_CTRL: rd_byte = {5'h00, filter_ff};
      IDX_MARGIN_CTRL: rd_byte = {6'h00, option_ff};
      IDX_ACTIVE_OFS: rd_byte = active_ff[7:0];
      default: rd_hit = 1'b0;
    endcase
  end
  wire [DATA_W-1:0] rd_word = (rd_idx == IDX_ACTIVE_OFS) ?
    {22'h0, active_ff} : {24'h0, rd_byte};

  // bus handshake state
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= '0;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else
      begin
        if (aw_take)
        begin
          aw_held_ff <= 1'b1;
          aw_addr_ff <= s_axi_awaddr_in;
        end
        if (w_take)
        begin
          w_held_ff <= 1'b1;
          w_data_ff <= s_axi_wdata_in;
          w_strb_ff <= s_axi_wstrb_in;
        end
        if (bvalid_ff && s_axi_bready_in)
          bvalid_ff <= 1'b0;
      end
      if (ar_take)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_hit ? rd_word : '0;
        rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready_in)
        rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rresp_out = rresp_ff;
  assign s_axi_rdata_out = rdata_ff;

  // analog controls driven straight from the fields
  assign active_offset_out = active_ff;
  assign synth_one_pulse_stretch_out = stretch_ff;
  assign synth_one_filter_order_out = filter_ff;
  assign synth_one_third_order_out = (filter_ff == FILT_THIRD);
  assign synth_one_min_pulse_ps_out = stretch_ff ? 10'(PULSE_WIDE_PS) :
                                                   10'(PULSE_NARROW_PS);

  a_pulse_width: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !stretch_ff |-> synth_one_min_pulse_ps_out == 10'd200)
    else $error("narrow pulse width wrong");
  a_pulse_wide: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    stretch_ff |-> synth_one_min_pulse_ps_out == 10'd600)
    else $error("wide pulse width wrong");
  a_third_order: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    synth_one_third_order_out == (synth_one_filter_order_out == 3'h7))
    else $error("third order flag wrong");
  a_second_order: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    synth_one_filter_order_out == 3'h3 |-> !synth_one_third_order_out)
    else $error("second order code flagged third");
  a_filter_reset: assert property (@(posedge clock_in)
    !rst_b_in |=> filter_ff == 3'h3)
    else $error("filter reset value wrong");
  a_step5_reset: assert property (@(posedge clock_in)
    !rst_b_in |=> step5_low_ff == 8'hbe)
    else $error("step five reset value wrong");
  a_step_words: assert property (@(posedge clock_in)
    !rst_b_in |=> step6_w == 10'h1fe && step7_w == 10'h247 && step8_w == 10'h29e)
    else $error("step word reset wrong");
  a_soft_apply: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    option_ff == 2'h2 && $stable(option_ff) && $stable(soft_w) |=> active_ff == $past(soft_w))
    else $error("soft offset not applied");
  a_soft_reset: assert property (@(posedge clock_in)
    !rst_b_in |=> soft_w == 10'h000)
    else $error("soft offset reset value wrong");
  a_gate_nominal: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    option_ff == 2'h0 && gate_high |=> active_ff == 10'h000)
    else $error("gated step not nominal");
  a_step8_pick: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    option_ff == 2'h1 && step_sel == 3'h7 |=> active_ff == $past(step8_w))
    else $error("step eight not applied");
  a_reserved_zero: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    rvalid_ff && $rose(rvalid_ff) && rresp_ff == 2'h0 |-> rdata_ff[31:10] == 22'h0)
    else $error("reserved bits not zero");
endmodule

/* File: core/margin_cfg_pkg.sv */
// constants for the margining offset and synthesizer-one configuration bank
package margin_cfg_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int OFS_W = 10;
  localparam int BYTE_W = 8;
  localparam int HIGH_W = 2;
  localparam int FILT_W = 3;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_STEP5_LOW = 8'h61;
  localparam logic [7:0] IDX_STEP6_HIGH = 8'h62;
  localparam logic [7:0] IDX_STEP6_LOW = 8'h63;
  localparam logic [7:0] IDX_STEP7_HIGH = 8'h64;
  localparam logic [7:0] IDX_STEP7_LOW = 8'h65;
  localparam logic [7:0] IDX_STEP8_HIGH = 8'h66;
  localparam logic [7:0] IDX_STEP8_LOW = 8'h67;
  localparam logic [7:0] IDX_SOFT_HIGH = 8'h68;
  localparam logic [7:0] IDX_SOFT_LOW = 8'h69;
  localparam logic [7:0] IDX_PULSE_CTRL = 8'h75;
  localparam logic [7:0] IDX_FILTER_CTRL = 8'h76;
  // own register: margin option and active offset readback
  localparam logic [7:0] IDX_MARGIN_CTRL = 8'h80;
  localparam logic [7:0] IDX_ACTIVE_OFS = 8'h81;
  // reset values
  localparam logic [7:0] RST_STEP5_LOW = 8'hbe;
  localparam logic [1:0] RST_STEP6_HIGH = 2'h1;
  localparam logic [7:0] RST_STEP6_LOW = 8'hfe;
  localparam logic [1:0] RST_STEP7_HIGH = 2'h2;
  localparam logic [7:0] RST_STEP7_LOW = 8'h47;
  localparam logic [1:0] RST_STEP8_HIGH = 2'h2;
  localparam logic [7:0] RST_STEP8_LOW = 8'h9e;
  localparam logic [1:0] RST_SOFT_HIGH = 2'h0;
  localparam logic [7:0] RST_SOFT_LOW = 8'h00;
  localparam logic RST_STRETCH = 1'b0;
  localparam logic [2:0] RST_FILTER = 3'h3;
  localparam logic [1:0] RST_OPTION = 2'h0;
  // field positions
  localparam int STRETCH_BIT = 7;
  // filter codes
  localparam logic [2:0] FILT_SECOND = 3'h3;
  localparam logic [2:0] FILT_THIRD = 3'h7;
  // margin option codes
  localparam logic [1:0] OPT_PIN_GATED = 2'h0;
  localparam logic [1:0] OPT_PIN = 2'h1;
  localparam logic [1:0] OPT_SOFT = 2'h2;
  // minimum phase-detector pulse widths in ps
  localparam int PULSE_NARROW_PS = 200;
  localparam int PULSE_WIDE_PS = 600;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] NOMINAL_STEP = 3'h3;
endpackage

/* File: core/offset_word_reg.sv */
// one split margining offset word: high two bits and low byte
`timescale 1ns/1ns
module offset_word_reg
  import margin_cfg_pkg::*;
#(
  parameter logic [1:0] HIGH_RST = 2'h0,
  parameter logic [7:0] LOW_RST = 8'h00
)(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic high_we_in,
  input wire logic low_we_in,
  input wire logic [7:0] wdata_in,
  output logic [margin_cfg_pkg::OFS_W-1:0] word_out
);
  logic [1:0] high_ff;
  logic [7:0] low_ff;
  // reserved upper bits of the high byte are simply not stored
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      high_ff <= HIGH_RST;
      low_ff <= LOW_RST;
    end
    else
    begin
      if (high_we_in)
        high_ff <= wdata_in[1:0];
      if (low_we_in)
        low_ff <= wdata_in;
    end
  end
  assign word_out = {high_ff, low_ff};
endmodule

/* File: core/sync_two_ff.sv */
// two-flop synchroniser for a pin level
`timescale 1ns/1ns
module sync_two_ff #(
  parameter int WIDTH = 1
)(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  // first stage feeds only the second
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end
  assign sync_out = sync_ff;
endmodule

/* File: test/test_xo_margin_pll_cfg_regs.sv */
// self-checking bench for the margining offset and synthesizer-one register bank
`timescale 1ns/1ns
module test_xo_margin_pll_cfg_regs;
  import margin_cfg_pkg::*;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr_in = '0;
  logic s_axi_awvalid_in = 1'b0;
  logic [DATA_W-1:0] s_axi_wdata_in = '0;
  logic [3:0] s_axi_wstrb_in = 4'h0;
  logic s_axi_wvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr_in = '0;
  logic s_axi_arvalid_in = 1'b0;
  logic s_axi_rready_in = 1'b0;
  logic [2:0] step_select_pin_in = 3'h0;
  logic margin_gate_pin_in = 1'b0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, synth_one_pulse_stretch_out, synth_one_third_order_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [DATA_W-1:0] s_axi_rdata_out;
  logic [OFS_W-1:0] active_offset_out;
  logic [FILT_W-1:0] synth_one_filter_order_out;
  logic [9:0] synth_one_min_pulse_ps_out;
  int fails = 0;
  int total_checks = 0;

  xo_margin_pll_cfg_regs dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in), .step_select_pin_in(step_select_pin_in),
    .margin_gate_pin_in(margin_gate_pin_in), .active_offset_out(active_offset_out),
    .synth_one_pulse_stretch_out(synth_one_pulse_stretch_out),
    .synth_one_filter_order_out(synth_one_filter_order_out),
    .synth_one_third_order_out(synth_one_third_order_out),
    .synth_one_min_pulse_ps_out(synth_one_min_pulse_ps_out));

  // 50 ns period
  always #25 clock_in = ~clock_in;

  // registers sit on word boundaries, so the byte address is four times the index
  function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // both channels offered together, each released once taken
  task automatic axi_write(input logic [7:0] idx, input logic [31:0] data,
                           input logic [3:0] strb, input logic [1:0] resp);
    int n;
    logic aw_done;
    logic w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clock_in);
    s_axi_awaddr_in <= addr_of(idx);
    s_axi_awvalid_in <= 1'b1;
    s_axi_wdata_in <= data;
    s_axi_wstrb_in <= strb;
    s_axi_wvalid_in <= 1'b1;
    while (!(aw_done && w_done) && n < 100)
    begin
      @(posedge clock_in);
      n++;
      if (!aw_done && s_axi_awready_out === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (!w_done && s_axi_wready_out === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    s_axi_bready_in <= 1'b1;
    do
    begin
      @(posedge clock_in);
      n++;
    end
    while (s_axi_bvalid_out !== 1'b1 && n < 200);
    s_axi_bready_in <= 1'b0;
    check(32'(n < 200), 32'h1);
    check(32'(s_axi_bresp_out), 32'(resp));
  endtask

  // read one word and compare data and response
  task automatic axi_read(input logic [7:0] idx, input logic [31:0] exp,
                          input logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clock_in);
    s_axi_araddr_in <= addr_of(idx);
    s_axi_arvalid_in <= 1'b1;
    do
    begin
      @(posedge clock_in);
      n++;
    end
    while (s_axi_arready_out !== 1'b1 && n < 100);
    s_axi_arvalid_in <= 1'b0;
    s_axi_rready_in <= 1'b1;
    do
    begin
      @(posedge clock_in);
      n++;
    end
    while (s_axi_rvalid_out !== 1'b1 && n < 200);
    s_axi_rready_in <= 1'b0;
    check(32'(n < 200), 32'h1);
    check(s_axi_rdata_out, exp);
    check(32'(s_axi_rresp_out), 32'(resp));
  endtask

  task automatic test_reset_values;
    logic [7:0] idx [11] = '{8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68,
                             8'h69, 8'h75, 8'h76};
    logic [31:0] exp [11] = '{32'hbe, 32'h1, 32'hfe, 32'h2, 32'h47, 32'h2, 32'h9e, 32'h0,
                              32'h0, 32'h0, 32'h3};
    for (int i = 0; i < 11; i++)
      axi_read(idx[i], exp[i], 2'h0);
    check(32'(synth_one_pulse_stretch_out), 32'h0);
    check(32'(synth_one_min_pulse_ps_out), 32'd200);
    check(32'(synth_one_filter_order_out), 32'h3);
    check(32'(synth_one_third_order_out), 32'h0);
    $display("test reset_values done");
  endtask

  // all-ones writes show which bits exist; filter codes kept to the legal pair
  task automatic test_fields;
    axi_write(8'h62, 32'hffffffff, 4'hf, 2'h0);
    axi_read(8'h62, 32'h3, 2'h0);
    axi_write(8'h62, 32'h1, 4'hf, 2'h0);
    axi_write(8'h75, 32'hffffffff, 4'hf, 2'h0);
    axi_read(8'h75, 32'h80, 2'h0);
    check(32'(synth_one_pulse_stretch_out), 32'h1);
    check(32'(synth_one_min_pulse_ps_out), 32'd600);
    axi_write(8'h76, 32'hfffffff7, 4'hf, 2'h0);
    axi_read(8'h76, 32'h7, 2'h0);
    check(32'(synth_one_filter_order_out), 32'h7);
    check(32'(synth_one_third_order_out), 32'h1);
    axi_write(8'h76, 32'h3, 4'hf, 2'h0);
    check(32'(synth_one_third_order_out), 32'h0);
    axi_write(8'h75, 32'h0, 4'hf, 2'h0);
    check(32'(synth_one_min_pulse_ps_out), 32'd200);
    axi_write(8'h61, 32'h55, 4'he, 2'h0);
    axi_read(8'h61, 32'hbe, 2'h0);
    $display("test fields done");
  endtask

  // pin-chosen steps; step seven rewritten so the split is seen on a fresh value
  task automatic test_pin_steps;
    logic [9:0] exp [4] = '{10'h0be, 10'h1fe, 10'h123, 10'h29e};
    axi_write(8'h64, 32'h1, 4'hf, 2'h0);
    axi_write(8'h65, 32'h23, 4'hf, 2'h0);
    axi_write(8'h80, 32'h1, 4'hf, 2'h0);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clock_in);
      step_select_pin_in <= (i < 4) ? 3'(i + 4) : 3'h0;
      repeat (4) @(posedge clock_in);
      check(32'(active_offset_out), (i < 4) ? 32'(exp[i]) : 32'h0);
    end
    axi_write(8'h80, 32'h0, 4'hf, 2'h0);
    @(posedge clock_in);
    step_select_pin_in <= 3'h5;
    margin_gate_pin_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    check(32'(active_offset_out), 32'h0);
    margin_gate_pin_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    check(32'(active_offset_out), 32'h1fe);
    axi_read(8'h81, 32'h1fe, 2'h0);
    // option three ignores the gate pin like option one
    axi_write(8'h80, 32'h3, 4'hf, 2'h0);
    margin_gate_pin_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    check(32'(active_offset_out), 32'h1fe);
    axi_read(8'h80, 32'h3, 2'h0);
    margin_gate_pin_in <= 1'b0;
    $display("test pin_steps done");
  endtask

  // soft offset overrides whatever the pins select
  task automatic test_soft_offset;
    axi_write(8'h68, 32'hfe, 4'hf, 2'h0);
    axi_write(8'h69, 32'h5a, 4'hf, 2'h0);
    axi_read(8'h68, 32'h2, 2'h0);
    axi_write(8'h80, 32'h2, 4'hf, 2'h0);
    repeat (3) @(posedge clock_in);
    check(32'(active_offset_out), 32'h25a);
    axi_write(8'h70, 32'hff, 4'hf, 2'h2);
    axi_read(8'h70, 32'h0, 2'h2);
    $display("test soft_offset done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // the whole sequence needs well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clock_in);
    fails++;
    print_verdict();
  end

  initial
  begin
    repeat (6) @(posedge clock_in);
    rst_b_in <= 1'b1;
    test_reset_values();
    test_fields();
    test_pin_steps();
    test_soft_offset();
    print_verdict();
  end
endmodule
